//--- verilog/lsgi_pkg.sv
// Shared constants and types for the display scan and interrupt block.
package lsgi_pkg;
   localparam int          AXI_AW      = 18;
   localparam int          IDX_W       = 16;
   // Register indices; the byte address is four times the index.
   localparam logic [15:0] IDX_PRIO    = 16'hFF21;
   localparam logic [15:0] IDX_IRQ_EN  = 16'hFF25;
   localparam logic [15:0] IDX_FLAGS   = 16'hFF29;
   localparam logic [15:0] IDX_MODE    = 16'hFF60;
   localparam logic [15:0] IDX_XFER    = 16'hFF61;
   localparam logic [15:0] IDX_LBC     = 16'hFF62;
   localparam logic [15:0] IDX_SA_LO   = 16'hFF63;
   localparam logic [15:0] IDX_SA_HI   = 16'hFF64;
   localparam logic [15:0] IDX_LINES   = 16'hFF65;
   localparam logic [15:0] IDX_PITCH   = 16'hFF67;
   localparam logic [15:0] IDX_GS1     = 16'hFF68;
   localparam logic [15:0] IDX_GS2     = 16'hFF69;
   localparam logic [15:0] IDX_GS3     = 16'hFF6A;
   // Field positions.
   localparam int          EN_BIT      = 2;
   localparam int          FLAG_BIT    = 2;
   localparam int          GRAY_BIT    = 1;
   localparam int          CONT_BIT    = 0;
   localparam int          OS_BIT      = 1;
   localparam int          AUTO_BIT    = 2;
   localparam int          PWR_BIT     = 3;
   localparam int          ABUSY_BIT   = 4;
   // Values after reset.
   localparam logic [7:0]  BYTE_RST    = 8'h00;
   localparam logic [15:0] ADDR_RST    = 16'h0000;
   localparam logic [1:0]  PRIO_RST    = 2'h0;
   localparam logic        CONT_RST    = 1'b1;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {S_IDLE, S_READ, S_WAIT, S_OUT} lsgi_scan_st_t;
endpackage

//--- verilog/lsgi_scan_if.sv
// Settings and status passed between the register side and the scanner.
`timescale 1ns/1ns
interface lsgi_scan_if;
   logic        start;
   logic        gray;
   logic [15:0] start_addr;
   logic [7:0]  pitch;
   logic [6:0]  line_byte_count;
   logic [7:0]  lines;
   logic [7:0]  gs1;
   logic [7:0]  gs2;
   logic [7:0]  gs3;
   logic        busy;
   logic        done;
   modport ctl (output start, gray, start_addr, pitch, line_byte_count, lines,
                gs1, gs2, gs3, input busy, done);
   modport eng (input start, gray, start_addr, pitch, line_byte_count, lines,
                gs1, gs2, gs3, output busy, done);
endinterface

//--- verilog/lsgi_scan.sv
// Frame scanner: fetches display memory and emits 4-dot nibbles.
`timescale 1ns/1ns
module lsgi_scan
   import lsgi_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   lsgi_scan_if.eng         sif,
   output logic [15:0]      mem_addr,
   output logic             mem_rd,
   input  wire logic [7:0]  mem_rdata,
   output logic [3:0]       seg_data,
   output logic             seg_strobe,
   output logic             frame_start
);
   lsgi_scan_st_t st_r;
   logic [15:0]   addr_r;
   logic [6:0]    col_r;
   logic [7:0]    row_r;
   logic [7:0]    data_r;
   logic [3:0]    seg_r;
   logic [2:0]    frm_r;
   logic          nib_r;
   logic          gray_r;
   logic          done_r;
   logic          fs_r;
   logic          strobe_r;
   logic [3:0]    gnib;

   wire        empty    = (sif.line_byte_count == 7'h00) || (sif.lines == 8'h00);
   wire        last_col = (col_r == sif.line_byte_count - 7'h01);
   wire        last_row = (row_r == sif.lines - 8'h01);
   wire        byte_end = (st_r == S_OUT) && (gray_r || nib_r);
   wire [3:0]  bnib     = nib_r ? data_r[3:0] : data_r[7:4];
   wire [15:0] nxt_line = addr_r + 16'h0001 + {8'h00, sif.pitch};

   // Dot i of a gray nibble takes bits 2i+1:2i; the leftmost dot is bit 3.
   for (genvar i = 0; i < 4; i++) begin : g_dot
      wire [1:0] code = data_r[2*i+1:2*i];
      assign gnib[i] = (code == 2'h1) ? sif.gs1[frm_r] :
                       (code == 2'h2) ? sif.gs2[frm_r] :
                       (code == 2'h3) ? sif.gs3[frm_r] : 1'b0;
   end

   assign sif.busy    = (st_r != S_IDLE);
   assign sif.done    = done_r;
   assign mem_addr    = addr_r;
   assign mem_rd      = (st_r == S_READ);
   assign seg_data    = seg_r;
   assign seg_strobe  = strobe_r;
   assign frame_start = fs_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r     <= S_IDLE;
         addr_r   <= ADDR_RST;
         col_r    <= 7'h00;
         row_r    <= 8'h00;
         data_r   <= 8'h00;
         seg_r    <= 4'h0;
         frm_r    <= 3'h0;
         nib_r    <= 1'b0;
         gray_r   <= 1'b0;
         done_r   <= 1'b0;
         fs_r     <= 1'b0;
         strobe_r <= 1'b0;
      end else begin
         done_r   <= 1'b0;
         strobe_r <= 1'b0;
         fs_r     <= 1'b0;
         case (st_r)
            S_IDLE: if (sif.start) begin
               if (empty) begin
                  done_r <= 1'b1;
                  frm_r  <= frm_r + 3'h1;
               end else begin
                  st_r   <= S_READ;
                  addr_r <= sif.start_addr;
                  col_r  <= 7'h00;
                  row_r  <= 8'h00;
                  gray_r <= sif.gray;
               end
            end
            S_READ: st_r <= S_WAIT;
            S_WAIT: begin
               data_r <= mem_rdata;
               nib_r  <= 1'b0;
               st_r   <= S_OUT;
            end
            S_OUT: begin
               seg_r    <= gray_r ? gnib : bnib;
               strobe_r <= 1'b1;
               fs_r     <= (col_r == 7'h00) && (row_r == 8'h00) && !nib_r;
               nib_r    <= 1'b1;
               if (byte_end) begin
                  st_r <= S_READ;
                  if (last_col) begin
                     col_r  <= 7'h00;
                     addr_r <= nxt_line;
                     if (last_row) begin
                        st_r   <= S_IDLE;
                        done_r <= 1'b1;
                        frm_r  <= frm_r + 3'h1;
                     end else begin
                        row_r <= row_r + 8'h01;
                     end
                  end else begin
                     col_r  <= col_r + 7'h01;
                     addr_r <= addr_r + 16'h0001;
                  end
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_start_addr_used: assert property (
      (st_r == S_IDLE) && sif.start && !empty
      |=> mem_rd && (mem_addr == $past(sif.start_addr)))
      else $error("Frame did not fetch from the start address.");
   a_pitch_skip: assert property (
      byte_end && last_col && !last_row
      |=> addr_r == $past(addr_r) + 16'h0001 + {8'h00, $past(sif.pitch)})
      else $error("Next line did not skip the pitch bytes.");
   a_code_zero_off: assert property (
      (st_r == S_OUT) && gray_r && (data_r[7:6] == 2'h0)
      |=> seg_strobe && !seg_data[3])
      else $error("Gray code zero dot was lit.");
   a_gray_level3: assert property (
      (st_r == S_OUT) && gray_r && (data_r[1:0] == 2'h3)
      |=> seg_data[0] == $past(sif.gs3[frm_r]))
      else $error("Level 3 dot does not follow its frame pattern bit.");
   a_frame_advance: assert property (
      sif.done |-> frm_r == $past(frm_r) + 3'h1)
      else $error("Frame counter did not advance at frame end.");
   a_bw_two_nibbles: assert property (
      (st_r == S_OUT) && !gray_r && !nib_r |=> (st_r == S_OUT) ##1 seg_strobe)
      else $error("Black and white byte did not yield two nibbles.");
   c_gray_frame: cover property (gray_r && sif.done);
   c_line_wrap: cover property (byte_end && last_col && !last_row);
endmodule // lsgi_scan

//--- verilog/lsgi_top.sv
// Display scan control, gray patterns and transfer interrupt behind AXI4-Lite.
// Operation
// - Each frame starts fetching at the programmed start address, reset zero.
// - A new start address takes effect at the next frame start.
// - After each line skip pitch bytes before the next line, reset zero.
// - Three 8-bit gray patterns serve pixel codes 01, 10 and 11.
// - Pattern bit n decides the dot in frame n of eight.
// - Reset clears all three gray patterns to zero.
// - Two-bit priority sets interrupt level; zero means no request.
// - Enable bit gates the transfer interrupt; reset clears it.
// - Flag sets when a one-shot or auto transfer completes.
// - Request only if flag, enable and priority above CPU mask.
// - Flag sets regardless of enable and priority.
// - Writing one clears the flag, zero does nothing; reset clears it.
// - Gray mode uses two bits per dot, black and white one.
// - Line length is programmed in bytes.
// - Writing one to the trigger starts a one-shot; reads busy.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
module lsgi_top
   import lsgi_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [AXI_AW-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [AXI_AW-1:0] araddr,
   input  wire logic [2:0]        arprot,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic [1:0]        cpu_mask_level,
   input  wire logic              disp_mem_write,
   output logic [15:0]            mem_addr,
   output logic                   mem_rd,
   input  wire logic [7:0]        mem_rdata,
   output logic [3:0]             seg_data,
   output logic                   seg_strobe,
   output logic                   frame_start,
   output logic                   panel_power_enable,
   output logic                   irq_request,
   output logic [1:0]             irq_level
);
   logic              aw_got_r;
   logic              w_got_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic [AXI_AW-1:0] waddr_r;
   logic [7:0]        wbyte_r;
   logic              wlane_r;
   logic              rvalid_r;
   logic [1:0]        rresp_r;
   logic [7:0]        rbyte_r;
   logic [7:0]        rd_byte;
   logic              rd_hit;

   logic [1:0]        prio_r;
   logic              irq_en_r;
   logic              flag_r;
   logic              gray_r;
   logic              cont_r;
   logic              auto_r;
   logic              pwr_r;
   logic [6:0]        lbc_r;
   logic [15:0]       sa_r;
   logic [7:0]        lines_r;
   logic [7:0]        pitch_r;
   logic [7:0]        gs1_r;
   logic [7:0]        gs2_r;
   logic [7:0]        gs3_r;
   logic              os_busy_r;
   logic              os_run_r;
   logic              auto_pend_r;
   logic              auto_run_r;
   logic              irq_r;

   lsgi_scan_if sif ();

   // Write channel: address and data are taken in either order.
   assign awready = !aw_got_r && !bvalid_r;
   assign wready  = !w_got_r && !bvalid_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;

   wire [IDX_W-1:0] w_idx = waddr_r[AXI_AW-1:2];
   wire             w_ok  = (waddr_r[1:0] == 2'h0);
   wire             wr_go = aw_got_r && w_got_r && !bvalid_r;
   wire             wr_en = wr_go && wlane_r && w_ok;
   wire [7:0]       wd    = wbyte_r;

   wire sel_prio  = wr_en && (w_idx == IDX_PRIO);
   wire sel_en    = wr_en && (w_idx == IDX_IRQ_EN);
   wire sel_flag  = wr_en && (w_idx == IDX_FLAGS);
   wire sel_mode  = wr_en && (w_idx == IDX_MODE);
   wire sel_xfer  = wr_en && (w_idx == IDX_XFER);
   wire sel_lbc   = wr_en && (w_idx == IDX_LBC);
   wire sel_sa_lo = wr_en && (w_idx == IDX_SA_LO);
   wire sel_sa_hi = wr_en && (w_idx == IDX_SA_HI);
   wire sel_lines = wr_en && (w_idx == IDX_LINES);
   wire sel_pitch = wr_en && (w_idx == IDX_PITCH);
   wire sel_gs1   = wr_en && (w_idx == IDX_GS1);
   wire sel_gs2   = wr_en && (w_idx == IDX_GS2);
   wire sel_gs3   = wr_en && (w_idx == IDX_GS3);

   wire w_map = w_ok && ((w_idx == IDX_PRIO) || (w_idx == IDX_IRQ_EN) ||
                (w_idx == IDX_FLAGS) || (w_idx == IDX_MODE) ||
                (w_idx == IDX_XFER) || (w_idx == IDX_LBC) ||
                (w_idx == IDX_SA_LO) || (w_idx == IDX_SA_HI) ||
                (w_idx == IDX_LINES) || (w_idx == IDX_PITCH) ||
                (w_idx == IDX_GS1) || (w_idx == IDX_GS2) ||
                (w_idx == IDX_GS3));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
         waddr_r  <= '0;
         wbyte_r  <= BYTE_RST;
         wlane_r  <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            aw_got_r <= 1'b1;
            waddr_r  <= awaddr;
         end else if (wr_go) begin
            aw_got_r <= 1'b0;
         end
         if (wvalid && wready) begin
            w_got_r <= 1'b1;
            wbyte_r <= wdata[7:0];
            wlane_r <= wstrb[0];
         end else if (wr_go) begin
            w_got_r <= 1'b0;
         end
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= w_map ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read channel: one-cycle answer; bits of other peripherals read zero.
   wire [IDX_W-1:0] r_idx = araddr[AXI_AW-1:2];
   wire             r_ok  = (araddr[1:0] == 2'h0);
   wire             ar_go = arvalid && arready;

   always_comb begin
      rd_byte = 8'h00;
      rd_hit  = r_ok;
      if (r_idx == IDX_PRIO) begin
         rd_byte = {6'h00, prio_r};
      end else if (r_idx == IDX_IRQ_EN) begin
         rd_byte[EN_BIT] = irq_en_r;
      end else if (r_idx == IDX_FLAGS) begin
         rd_byte[FLAG_BIT] = flag_r;
      end else if (r_idx == IDX_MODE) begin
         rd_byte[GRAY_BIT] = gray_r;
      end else if (r_idx == IDX_XFER) begin
         rd_byte[CONT_BIT]  = cont_r;
         rd_byte[OS_BIT]    = os_busy_r;
         rd_byte[AUTO_BIT]  = auto_r;
         rd_byte[PWR_BIT]   = pwr_r;
         rd_byte[ABUSY_BIT] = auto_pend_r || auto_run_r;
      end else if (r_idx == IDX_LBC) begin
         rd_byte = {1'b0, lbc_r};
      end else if (r_idx == IDX_SA_LO) begin
         rd_byte = sa_r[7:0];
      end else if (r_idx == IDX_SA_HI) begin
         rd_byte = sa_r[15:8];
      end else if (r_idx == IDX_LINES) begin
         rd_byte = lines_r;
      end else if (r_idx == IDX_PITCH) begin
         rd_byte = pitch_r;
      end else if (r_idx == IDX_GS1) begin
         rd_byte = gs1_r;
      end else if (r_idx == IDX_GS2) begin
         rd_byte = gs2_r;
      end else if (r_idx == IDX_GS3) begin
         rd_byte = gs3_r;
      end else begin
         rd_hit = 1'b0;
      end
      if (!r_ok) begin
         rd_byte = 8'h00;
      end
   end

   assign arready = !rvalid_r;
   assign rvalid  = rvalid_r;
   assign rresp   = rresp_r;
   assign rdata   = {24'h000000, rbyte_r};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rresp_r  <= RESP_OKAY;
         rbyte_r  <= BYTE_RST;
      end else if (ar_go) begin
         rvalid_r <= 1'b1;
         rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         rbyte_r  <= rd_byte;
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Settings registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prio_r   <= PRIO_RST;
         irq_en_r <= 1'b0;
         gray_r   <= 1'b0;
         cont_r   <= CONT_RST;
         auto_r   <= 1'b0;
         pwr_r    <= 1'b0;
         lbc_r    <= 7'h00;
         sa_r     <= ADDR_RST;
         lines_r  <= BYTE_RST;
         pitch_r  <= BYTE_RST;
         gs1_r    <= BYTE_RST;
         gs2_r    <= BYTE_RST;
         gs3_r    <= BYTE_RST;
      end else begin
         if (sel_prio)  prio_r   <= wd[1:0];
         if (sel_en)    irq_en_r <= wd[EN_BIT];
         if (sel_mode)  gray_r   <= wd[GRAY_BIT];
         if (sel_xfer) begin
            cont_r <= wd[CONT_BIT];
            auto_r <= wd[AUTO_BIT];
            pwr_r  <= wd[PWR_BIT];
         end
         if (sel_lbc)   lbc_r    <= wd[6:0];
         if (sel_sa_lo) sa_r[7:0]  <= wd;
         if (sel_sa_hi) sa_r[15:8] <= wd;
         if (sel_lines) lines_r  <= wd;
         if (sel_pitch) pitch_r  <= wd;
         if (sel_gs1)   gs1_r    <= wd;
         if (sel_gs2)   gs2_r    <= wd;
         if (sel_gs3)   gs3_r    <= wd;
      end
   end

   // Transfer sequencing. A pending one-shot wins over auto, and both
   // wait for a running refresh frame to finish so frames stay whole.
   wire eng_idle   = !sif.busy && !os_run_r && !auto_run_r;
   wire os_trig    = sel_xfer && wd[OS_BIT] && !os_busy_r;
   wire start_os   = pwr_r && os_busy_r && eng_idle;
   wire start_auto = pwr_r && auto_pend_r && eng_idle && !start_os;
   wire start_cont = pwr_r && cont_r && eng_idle && !os_busy_r &&
                     !auto_pend_r;
   wire auto_hit   = disp_mem_write && auto_r && pwr_r;
   wire xfer_done  = sif.done && (os_run_r || auto_run_r);
   wire flag_clr   = sel_flag && wd[FLAG_BIT];

   assign sif.start      = start_os || start_auto || start_cont;
   assign sif.gray       = gray_r;
   assign sif.start_addr = sa_r;
   assign sif.pitch      = pitch_r;
   assign sif.line_byte_count        = lbc_r;
   assign sif.lines      = lines_r;
   assign sif.gs1        = gs1_r;
   assign sif.gs2        = gs2_r;
   assign sif.gs3        = gs3_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         os_busy_r   <= 1'b0;
         os_run_r    <= 1'b0;
         auto_pend_r <= 1'b0;
         auto_run_r  <= 1'b0;
      end else begin
         if (os_trig) os_busy_r <= 1'b1;
         else if (sif.done && os_run_r) os_busy_r <= 1'b0;
         if (start_os) os_run_r <= 1'b1;
         else if (sif.done) os_run_r <= 1'b0;
         if (auto_hit) auto_pend_r <= 1'b1;
         else if (start_auto) auto_pend_r <= 1'b0;
         if (start_auto) auto_run_r <= 1'b1;
         else if (sif.done) auto_run_r <= 1'b0;
      end
   end

   // A completion in the same cycle as a clearing write keeps the flag set.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_r <= 1'b0;
         irq_r  <= 1'b0;
      end else begin
         if (xfer_done) flag_r <= 1'b1;
         else if (flag_clr) flag_r <= 1'b0;
         irq_r <= flag_r && irq_en_r && (prio_r > cpu_mask_level);
      end
   end

   assign irq_request        = irq_r;
   assign irq_level          = prio_r;
   assign panel_power_enable = pwr_r;

   lsgi_scan u_scan (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .sif         (sif.eng),
      .mem_addr    (mem_addr),
      .mem_rd      (mem_rd),
      .mem_rdata   (mem_rdata),
      .seg_data    (seg_data),
      .seg_strobe  (seg_strobe),
      .frame_start (frame_start)
   );

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_flag_on_done: assert property (
      xfer_done |=> flag_r ##1 irq_request == ($past(irq_en_r) &&
         ($past(prio_r) > $past(cpu_mask_level))))
      else $error("Completion did not set the flag.");
   a_flag_w1c: assert property (
      flag_clr && !xfer_done |=> !flag_r)
      else $error("Writing one did not clear the flag.");
   a_flag_keep: assert property (
      flag_r && !flag_clr |=> flag_r)
      else $error("Flag dropped without a clearing write.");
   a_irq_gated: assert property (
      !irq_en_r [*2] |-> !irq_request)
      else $error("Interrupt raised while disabled.");
   a_level_zero: assert property (
      (prio_r == 2'h0) [*2] |-> !irq_request)
      else $error("Interrupt raised at priority level zero.");
   a_irq_raise: assert property (
      (flag_r && irq_en_r && (prio_r > cpu_mask_level)) [*2] |-> irq_request)
      else $error("Interrupt missing with flag, enable and priority.");
   a_oneshot_busy: assert property (
      os_trig |=> os_busy_r throughout (##[1:1000] xfer_done))
      else $error("One-shot busy not held until completion.");
   c_oneshot_done: cover property (os_run_r && xfer_done);
   c_auto_done: cover property (auto_run_r && xfer_done);
   c_irq_raised: cover property (!irq_request ##1 irq_request);
endmodule // lsgi_top

//--- tb/lsgi_mem_model.sv
// Display memory model answering one cycle after each fetch.
`timescale 1ns/1ns
module lsgi_mem_model (
   input  wire logic        aclk,
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_rd,
   output logic      [7:0]  mem_rdata
);
   // Outside a fetch the bus toggles, so stale data never passes as valid.
   always @(posedge aclk) begin
      mem_rdata <= mem_rd ? (mem_addr[7:0] ^ 8'hA5) : ~mem_rdata;
   end
endmodule // lsgi_mem_model

//--- tb/tb_top.sv
// Register, scan and interrupt tests for the display scan block.
`timescale 1ns/1ns
module tb_top;
   import lsgi_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, disp_mem_write, mem_rd;
   logic seg_strobe, frame_start, panel_power_enable, irq_request;
   logic [AXI_AW-1:0] awaddr, araddr;
   logic [2:0]        awprot, arprot;
   logic [31:0]       wdata, rdata;
   logic [3:0]        wstrb, seg_data, fn;
   logic [1:0]        bresp, rresp, cpu_mask_level, irq_level;
   logic [15:0]       mem_addr, aq [2];
   logic [7:0]        mem_rdata, d;
   logic [1:0]        r;
   int                fails, checked, cyc, na, nibs;
   lsgi_top dut_u (.*);
   lsgi_mem_model mem_u (.*);
   initial begin
      aclk = 1'b0;
      // The transfer clock runs from before power-up and is never stopped.
      forever #50 aclk = ~aclk;
   end
   task end_sim;
      $display("mismatches %0d, comparisons %0d", fails, checked);
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input logic [15:0] i, input logic [7:0] v);
      awaddr <= {i, 2'b00}; wdata <= {24'h000000, v};
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task rd(input logic [15:0] i);
      araddr <= {i, 2'b00}; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata[7:0]; r = rresp; rready <= 1'b0;
      @(posedge aclk);
   endtask
   task frame(input logic [7:0] x);
      na = 0;
      nibs = 0;
      fn = 4'h0;
      wr(IDX_XFER, x);
      if (x[AUTO_BIT]) begin
         disp_mem_write <= 1'b1;
         @(posedge aclk);
         disp_mem_write <= 1'b0;
      end
      do rd(IDX_FLAGS); while (d[FLAG_BIT] !== 1'b1);
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (mem_rd === 1'b1 && na < 2) begin
         aq[na] = mem_addr;
         na++;
      end
      // Strobed nibbles are counted; the first of a frame is kept.
      if (seg_strobe === 1'b1) begin
         nibs++;
         if (frame_start === 1'b1) fn = seg_data;
      end
      if (cyc == 20000) begin
         fails++;
         end_sim;
      end
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awprot, arprot, disp_mem_write, cpu_mask_level} = 9'h000;
      awaddr = 18'h00000; araddr = 18'h00000; wdata = 32'h0;
      wstrb = 4'hF; fails = 0; checked = 0; cyc = 0; na = 2;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(IDX_PRIO); chk(d, 16'h0000);
      rd(IDX_IRQ_EN); chk(d, 16'h0000);
      rd(IDX_FLAGS); chk(d, 16'h0000);
      rd(IDX_PITCH); chk(d, 16'h0000);
      rd(IDX_GS3); chk(d, 16'h0000);
      rd(IDX_SA_HI); chk(d, 16'h0000);
      rd(16'h0100); chk(r, RESP_SLVERR);
      wr(16'h0100, 8'h00); chk(r, RESP_SLVERR);
      wr(IDX_GS2, 8'h5A); chk(r, RESP_OKAY);
      rd(IDX_GS2); chk(d, 16'h005A);
      wr(IDX_LBC, 8'h01); wr(IDX_LINES, 8'h02); wr(IDX_PITCH, 8'h03);
      wr(IDX_SA_LO, 8'h34); wr(IDX_SA_HI, 8'h12);
      frame(8'h0A);
      chk(aq[0], 16'h1234);
      chk(fn, 16'h0009);
      chk(16'(nibs), 16'h0004);
      chk(panel_power_enable, 1'b1);
      chk(aq[1], 16'h1238);
      chk(irq_request, 1'b0);
      wr(IDX_PRIO, 8'h02); wr(IDX_IRQ_EN, 8'h04); cpu_mask_level <= 2'h1;
      repeat (3) @(posedge aclk);
      chk(irq_request, 1'b1);
      chk(irq_level, 2'h2);
      cpu_mask_level <= 2'h2;
      repeat (3) @(posedge aclk);
      chk(irq_request, 1'b0);
      wr(IDX_FLAGS, 8'h00); rd(IDX_FLAGS); chk(d, 16'h0004);
      wr(IDX_FLAGS, 8'h04); rd(IDX_FLAGS); chk(d, 16'h0000);
      wr(IDX_SA_LO, 8'h40);
      frame(8'h0A);
      chk(aq[0], 16'h1240);
      chk(fn, 16'h000E);
      wr(IDX_FLAGS, 8'h04);
      // Gray mode only under continuous refresh; data 27h holds codes 0,2,1,3.
      wr(IDX_SA_LO, 8'h82); wr(IDX_GS1, 8'hFF); wr(IDX_GS2, 8'h00);
      wr(IDX_GS3, 8'hFF); wr(IDX_MODE, 8'h02);
      fn = 4'h0;
      wr(IDX_XFER, 8'h09);
      repeat (30) @(posedge aclk);
      wr(IDX_XFER, 8'h08);
      repeat (10) @(posedge aclk);
      chk(fn, 16'h0003);
      rd(IDX_FLAGS); chk(d, 16'h0000);
      wr(IDX_MODE, 8'h00);
      frame(8'h0C);
      chk(aq[0], 16'h1282);
      chk(fn, 16'h0002);
      wr(IDX_FLAGS, 8'h04);
      wr(IDX_XFER, 8'h00);
      chk(panel_power_enable, 1'b0);
      end_sim;
   end
endmodule // tb_top
